// ### rtl/dcw_pkg.sv
`default_nettype none
package dcw_pkg;

  // byte-wide programming port geometry
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;

  // control word bytes, most significant byte at the lowest address
  localparam logic [5:0] ADDR_CW_B3 = 6'h1d; // bits 31:24
  localparam logic [5:0] ADDR_CW_B2 = 6'h1e; // bits 23:16
  localparam logic [5:0] ADDR_CW_B1 = 6'h1f; // bits 15:8
  localparam logic [5:0] ADDR_CW_B0 = 6'h20; // bits 7:0
  // shaped-keying multiplier registers, 12 bits each, high nibble first
  localparam logic [5:0] ADDR_OSK_COS_HI = 6'h21;
  localparam logic [5:0] ADDR_OSK_COS_LO = 6'h22;
  localparam logic [5:0] ADDR_OSK_CTL_HI = 6'h23;
  localparam logic [5:0] ADDR_OSK_CTL_LO = 6'h24;

  // control word field positions
  localparam int unsigned CW_BIT_NOCARE  = 27;
  localparam int unsigned CW_BIT_RSVD23  = 23;
  localparam int unsigned CW_BIT_BYPASS  = 21;
  localparam int unsigned CW_MULT_HI     = 20;
  localparam int unsigned CW_MULT_LO     = 16;
  localparam int unsigned CW_BIT_CLR1    = 15;
  localparam int unsigned CW_BIT_HOLD    = 14;
  localparam int unsigned CW_BIT_TRI     = 13;
  localparam int unsigned CW_MODE_HI     = 11;
  localparam int unsigned CW_MODE_LO     = 9;
  localparam int unsigned CW_BIT_INT_UPD = 8;
  localparam int unsigned CW_BIT_RSVD7   = 7;
  localparam int unsigned CW_BIT_ISINC   = 6;
  localparam int unsigned CW_BIT_OSK_EN  = 5;
  localparam int unsigned CW_BIT_OSK_INT = 4;
  localparam int unsigned CW_BIT_RSVD3   = 3;
  localparam int unsigned CW_BIT_RSVD2   = 2;
  localparam int unsigned CW_BIT_LSB1ST  = 1;
  localparam int unsigned CW_BIT_SDO_EN  = 0;

  // reset values: range and bypass bits set, everything else clear
  localparam logic [31:0] CW_RESET      = 32'h0060_0000;
  localparam logic [11:0] OSK_RESET     = 12'h000;
  localparam logic [11:0] OSK_FULLSCALE = 12'hfff;

  // legal multiplier range
  localparam logic [4:0] MULT_MIN = 5'h04;
  localparam logic [4:0] MULT_MAX = 5'h14;

  typedef enum logic [2:0] {
    DCW_MODE_SINGLE = 3'b000,
    DCW_MODE_FSK    = 3'b001,
    DCW_MODE_RFSK   = 3'b010,
    DCW_MODE_CHIRP  = 3'b011,
    DCW_MODE_BPSK   = 3'b100
  } dcw_mode_type;

endpackage : dcw_pkg
`default_nettype wire

// ### rtl/dcw_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dcw_link_if;
  logic       wr_stb;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;
  logic       ud_dev_o;
  logic       ud_dev_oe_n;
  logic       ud_host_o;
  logic       ud_host_oe_n;
  logic       ud_wire;

  // resolved level of the update-strobe pin; undriven reads low
  assign ud_wire = (~ud_dev_oe_n & ud_dev_o) | (~ud_host_oe_n & ud_host_o);

  modport dev (
    input  wr_stb, wr_addr, wr_data, ud_wire,
    output ud_dev_o, ud_dev_oe_n
  );
  modport host (
    input  ud_wire,
    output wr_stb, wr_addr, wr_data, ud_host_o, ud_host_oe_n
  );
endinterface : dcw_link_if
`default_nettype wire

// ### rtl/dcw_device.sv
`timescale 1ns/100ps
`default_nettype none
module dcw_device
  import dcw_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  dcw_link_if.dev          link,
  input  wire logic [11:0] osk_ramp_in,
  output logic      [4:0]  pll_mult_out,
  output logic             pll_mult_used_out,
  output logic             pll_bypass_out,
  output logic             acc1_clear_out,
  output logic             acc_hold_out,
  output logic             triangle_out,
  output dcw_mode_type     mode_out,
  output logic             update_apply_out,
  output logic             isinc_bypass_out,
  output logic             isinc_clk_en_out,
  output logic             osk_en_out,
  output logic             osk_internal_out,
  output logic      [11:0] osk_scale_cos_out,
  output logic      [11:0] osk_scale_ctl_out,
  output logic             lsb_first_out,
  output logic             sdo_en_out,
  output logic      [31:0] ctrl_word_out
);

  typedef struct packed {
    logic [31:0]  buf_cw;
    logic [31:0]  act_cw;
    logic [11:0]  buf_osk_cos;
    logic [11:0]  buf_osk_ctl;
    logic [11:0]  act_osk_cos;
    logic [11:0]  act_osk_ctl;
    logic         ud_prev;
    logic         ud_o;
    logic         ud_oe_n;
    logic         apply;
    logic         clr1;
    logic [4:0]   mult;
    logic         mult_used;
    logic         hold;
    logic         tri_en;
    dcw_mode_type mode;
    logic         isinc_byp;
    logic         isinc_clk;
    logic         osk_en;
    logic         osk_int;
    logic [11:0]  scale_cos;
    logic [11:0]  scale_ctl;
    logic         lsb_first;
    logic         sdo_en;
  } dcw_dev_state_type;

  dcw_dev_state_type state_q;
  dcw_dev_state_type state_d;

  // undefined codes fall back to single tone
  function automatic dcw_mode_type dcw_decode_mode(input logic [2:0] code);
    dcw_mode_type m;
    m = DCW_MODE_SINGLE;
    unique case (code)
      3'b001:  m = DCW_MODE_FSK;
      3'b010:  m = DCW_MODE_RFSK;
      3'b011:  m = DCW_MODE_CHIRP;
      3'b100:  m = DCW_MODE_BPSK;
      default: m = DCW_MODE_SINGLE;
    endcase
    return m;
  endfunction : dcw_decode_mode

  logic ud_rise;

  // the pin level is read back even when we drive it, so both update sources share one path
  assign ud_rise = link.ud_wire & ~state_q.ud_prev;

  // next state: update transfer, byte writes, derived outputs
  always_comb begin
    state_d         = state_q;
    state_d.clr1    = 1'b0;
    state_d.apply   = 1'b0;
    state_d.ud_prev = link.ud_wire;
    // internal update: one strobe the cycle after each byte write
    state_d.ud_o    = state_q.act_cw[CW_BIT_INT_UPD] & link.wr_stb;
    state_d.ud_oe_n = ~state_q.act_cw[CW_BIT_INT_UPD];
    // buffered contents move to the active set on a strobe edge
    if (ud_rise) begin
      state_d.act_cw      = state_q.buf_cw;
      state_d.act_osk_cos = state_q.buf_osk_cos;
      state_d.act_osk_ctl = state_q.buf_osk_ctl;
      state_d.apply       = 1'b1;
      if (state_q.buf_cw[CW_BIT_CLR1]) begin
        state_d.clr1                = 1'b1;
        state_d.act_cw[CW_BIT_CLR1] = 1'b0;
        state_d.buf_cw[CW_BIT_CLR1] = 1'b0;
      end
    end
    // a write in the same cycle lands in the buffer after the transfer
    if (link.wr_stb) begin
      unique case (link.wr_addr)
        ADDR_CW_B3:      state_d.buf_cw[31:24]     = link.wr_data;
        ADDR_CW_B2:      state_d.buf_cw[23:16]     = link.wr_data;
        ADDR_CW_B1:      state_d.buf_cw[15:8]      = link.wr_data;
        ADDR_CW_B0:      state_d.buf_cw[7:0]       = link.wr_data;
        ADDR_OSK_COS_HI: state_d.buf_osk_cos[11:8] = link.wr_data[3:0];
        ADDR_OSK_COS_LO: state_d.buf_osk_cos[7:0]  = link.wr_data;
        ADDR_OSK_CTL_HI: state_d.buf_osk_ctl[11:8] = link.wr_data[3:0];
        ADDR_OSK_CTL_LO: state_d.buf_osk_ctl[7:0]  = link.wr_data;
        default: ; // unmapped bytes are dropped
      endcase
    end
    // synchronous reset to constants only
    if (!rst_n_in) begin
      state_d             = '0;
      state_d.buf_cw      = CW_RESET;
      state_d.act_cw      = CW_RESET;
      state_d.buf_osk_cos = OSK_RESET;
      state_d.buf_osk_ctl = OSK_RESET;
      state_d.act_osk_cos = OSK_RESET;
      state_d.act_osk_ctl = OSK_RESET;
      state_d.ud_oe_n     = 1'b1;
    end
    // decoded outputs track the active word, reset included
    state_d.mult      = state_d.act_cw[CW_MULT_HI:CW_MULT_LO];
    state_d.mult_used = ~state_d.act_cw[CW_BIT_BYPASS];
    state_d.hold      = state_d.act_cw[CW_BIT_HOLD];
    state_d.tri_en    = state_d.act_cw[CW_BIT_TRI];
    state_d.mode      = dcw_decode_mode(state_d.act_cw[CW_MODE_HI:CW_MODE_LO]);
    state_d.isinc_byp = state_d.act_cw[CW_BIT_ISINC];
    state_d.isinc_clk = ~state_d.act_cw[CW_BIT_ISINC];
    state_d.osk_en    = state_d.act_cw[CW_BIT_OSK_EN];
    state_d.osk_int   = state_d.act_cw[CW_BIT_OSK_INT];
    state_d.lsb_first = state_d.act_cw[CW_BIT_LSB1ST];
    state_d.sdo_en    = state_d.act_cw[CW_BIT_SDO_EN];
    // without keying the datapath runs at full scale
    if (!state_d.act_cw[CW_BIT_OSK_EN]) begin
      state_d.scale_cos = OSK_FULLSCALE;
      state_d.scale_ctl = OSK_FULLSCALE;
    end else begin
      state_d.scale_cos = state_d.act_cw[CW_BIT_OSK_INT] ? osk_ramp_in : state_d.act_osk_cos;
      state_d.scale_ctl = state_d.act_osk_ctl;
    end
  end

  // single state register
  always_ff @(posedge ref_clk_in) begin
    state_q <= state_d;
  end

  assign link.ud_dev_o    = state_q.ud_o;
  assign link.ud_dev_oe_n = state_q.ud_oe_n;

  // outputs straight from the state register
  assign pll_mult_out      = state_q.mult;
  assign pll_mult_used_out = state_q.mult_used;
  assign pll_bypass_out    = state_q.act_cw[CW_BIT_BYPASS];
  assign acc1_clear_out    = state_q.clr1;
  assign acc_hold_out      = state_q.hold;
  assign triangle_out      = state_q.tri_en;
  assign mode_out          = state_q.mode;
  assign update_apply_out  = state_q.apply;
  assign isinc_bypass_out  = state_q.isinc_byp;
  assign isinc_clk_en_out  = state_q.isinc_clk;
  assign osk_en_out        = state_q.osk_en;
  assign osk_internal_out  = state_q.osk_int;
  assign osk_scale_cos_out = state_q.scale_cos;
  assign osk_scale_ctl_out = state_q.scale_ctl;
  assign lsb_first_out     = state_q.lsb_first;
  assign sdo_en_out        = state_q.sdo_en;
  assign ctrl_word_out     = state_q.act_cw;

endmodule : dcw_device
`default_nettype wire

// ### rtl/dcw_host.sv
`timescale 1ns/100ps
`default_nettype none
module dcw_host
  import dcw_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       rst_n_in,
  dcw_link_if.host        link,
  input  wire logic       cmd_valid_in,
  input  wire logic [5:0] cmd_addr_in,
  input  wire logic [7:0] cmd_data_in,
  input  wire logic       update_req_in,
  output logic            cmd_ready_out,
  output logic            int_update_out
);

  typedef struct packed {
    logic       wr;
    logic [5:0] addr;
    logic [7:0] data;
    logic       ud_o;
    logic       ud_oe_n;
    logic       ready;
    logic       int_buf;
    logic       int_act;
  } dcw_host_state_type;

  dcw_host_state_type state_q;
  dcw_host_state_type state_d;
  logic [7:0]         clean;
  logic               take;

  assign take = cmd_valid_in & state_q.ready;

  // sanitise each byte before it reaches the device
  always_comb begin
    clean = cmd_data_in;
    unique case (cmd_addr_in)
      ADDR_CW_B3: clean[CW_BIT_NOCARE - 24] = 1'b0;
      ADDR_CW_B2: begin
        clean[CW_BIT_RSVD23 - 16] = 1'b0;
        // out-of-range multipliers are clamped rather than refused
        if (clean[4:0] < MULT_MIN) begin
          clean[4:0] = MULT_MIN;
        end else if (clean[4:0] > MULT_MAX) begin
          clean[4:0] = MULT_MAX;
        end
      end
      ADDR_CW_B1: begin
        if (clean[CW_BIT_TRI - 8]) begin
          clean[CW_MODE_HI - 8:CW_MODE_LO - 8] = DCW_MODE_RFSK;
        end
      end
      ADDR_CW_B0: begin
        clean[CW_BIT_RSVD7] = 1'b0;
        clean[CW_BIT_RSVD3] = 1'b0;
        clean[CW_BIT_RSVD2] = 1'b0;
      end
      default: ;
    endcase
  end

  // write launch, pin strobe and direction tracking
  always_comb begin
    state_d         = state_q;
    state_d.wr      = take;
    state_d.ready   = 1'b1;
    state_d.ud_o    = 1'b0;
    state_d.ud_oe_n = 1'b1;
    if (take) begin
      state_d.addr = cmd_addr_in;
      state_d.data = clean;
      if (cmd_addr_in == ADDR_CW_B1) begin
        state_d.int_buf = cmd_data_in[CW_BIT_INT_UPD - 8];
      end
    end
    // drive the pin only while the device leaves it as an input
    if (update_req_in && !state_q.int_act) begin
      state_d.ud_o    = 1'b1;
      state_d.ud_oe_n = 1'b0;
    end
    // mirror the device transfer in every cycle the strobe wire is seen high
    if (link.ud_wire) begin
      state_d.int_act = state_q.int_buf;
    end
    if (!rst_n_in) begin
      state_d         = '0;
      state_d.ud_oe_n = 1'b1;
    end
  end

  // single state register
  always_ff @(posedge ref_clk_in) begin
    state_q <= state_d;
  end

  assign link.wr_stb       = state_q.wr;
  assign link.wr_addr      = state_q.addr;
  assign link.wr_data      = state_q.data;
  assign link.ud_host_o    = state_q.ud_o;
  assign link.ud_host_oe_n = state_q.ud_oe_n;
  assign cmd_ready_out     = state_q.ready;
  assign int_update_out    = state_q.int_act;

endmodule : dcw_host
`default_nettype wire

// ### dv/dcw_link_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module dcw_link_monitor
  import dcw_pkg::*;
(
  input wire logic        ref_clk_in,
  input wire logic        rst_n_in,
  input wire logic        wr_stb,
  input wire logic [5:0]  wr_addr,
  input wire logic [7:0]  wr_data,
  input wire logic        ud_dev_oe_n,
  input wire logic        ud_wire,
  input wire logic        acc1_clear_out,
  input wire logic        update_apply_out,
  input wire logic [31:0] ctrl_word_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // host edits on bytes leaving for the device
  AST_MULT_RANGE: assert property (wr_stb && wr_addr == ADDR_CW_B2 |-> wr_data[4:0] inside {[5'h04:5'h14]})
    else $error("multiplier byte out of range");
  AST_RSVD_ZERO: assert property (wr_stb && wr_addr == ADDR_CW_B0 |-> (wr_data & 8'h8c) == 8'h00)
    else $error("reserved bits sent as one");
  AST_TRI_RFSK: assert property (wr_stb && wr_addr == ADDR_CW_B1 && wr_data[5] |-> wr_data[3:1] == 3'b010)
    else $error("triangle without ramped mode");
  // one-shot clear is one cycle and rides the apply pulse
  AST_CLR_ONE: assert property (acc1_clear_out |=> !acc1_clear_out)
    else $error("clear pulse longer than one cycle");
  AST_CLR_APPLY: assert property (acc1_clear_out |-> update_apply_out)
    else $error("clear pulse without apply");
  AST_CLR_SELF: assert property (!ctrl_word_out[CW_BIT_CLR1])
    else $error("clear bit seen in active word");
  // pin direction follows active bit 8, one cycle of slack after a change
  AST_PIN_OUT: assert property (ctrl_word_out[8] && $past(ctrl_word_out[8]) |-> !ud_dev_oe_n)
    else $error("device not driving strobe pin");
  AST_PIN_IN: assert property (!ctrl_word_out[8] && !$past(ctrl_word_out[8]) |-> ud_dev_oe_n)
    else $error("device drives strobe pin as input");
  AST_APPLY: assert property ($rose(ud_wire) |=> update_apply_out)
    else $error("strobe edge not applied");
  COV_CLR: cover property (acc1_clear_out);
  COV_EDGE: cover property ($rose(ud_wire));
  COV_INT: cover property (!ud_dev_oe_n);
endmodule : dcw_link_monitor
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import dcw_pkg::*;
();
  logic ref_clk_in, rst_n_in, cmd_valid_in, update_req_in, cmd_ready_out, int_update_out;
  logic [5:0] cmd_addr_in;
  logic [7:0] cmd_data_in;
  logic [11:0] osk_ramp_in, osk_scale_cos_out, osk_scale_ctl_out;
  logic [4:0] pll_mult_out;
  logic pll_mult_used_out, pll_bypass_out, acc1_clear_out, acc_hold_out, triangle_out, update_apply_out;
  logic isinc_bypass_out, isinc_clk_en_out, osk_en_out, osk_internal_out, lsb_first_out, sdo_en_out;
  dcw_mode_type mode_out;
  logic [31:0] ctrl_word_out;
  int n_tests, n_mismatch, n_clr, c0;
  dcw_link_if dcw_link_if_inst();
  dcw_host dcw_host_inst(.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .link(dcw_link_if_inst),
    .cmd_valid_in(cmd_valid_in), .cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in),
    .update_req_in(update_req_in), .cmd_ready_out(cmd_ready_out), .int_update_out(int_update_out));
  dcw_device dcw_device_inst(.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .link(dcw_link_if_inst),
    .osk_ramp_in(osk_ramp_in), .pll_mult_out(pll_mult_out), .pll_mult_used_out(pll_mult_used_out),
    .pll_bypass_out(pll_bypass_out), .acc1_clear_out(acc1_clear_out), .acc_hold_out(acc_hold_out),
    .triangle_out(triangle_out), .mode_out(mode_out), .update_apply_out(update_apply_out),
    .isinc_bypass_out(isinc_bypass_out), .isinc_clk_en_out(isinc_clk_en_out), .osk_en_out(osk_en_out),
    .osk_internal_out(osk_internal_out), .osk_scale_cos_out(osk_scale_cos_out),
    .osk_scale_ctl_out(osk_scale_ctl_out), .lsb_first_out(lsb_first_out), .sdo_en_out(sdo_en_out),
    .ctrl_word_out(ctrl_word_out));
  dcw_link_monitor dcw_link_monitor_inst(.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .wr_stb(dcw_link_if_inst.wr_stb), .wr_addr(dcw_link_if_inst.wr_addr), .wr_data(dcw_link_if_inst.wr_data),
    .ud_dev_oe_n(dcw_link_if_inst.ud_dev_oe_n), .ud_wire(dcw_link_if_inst.ud_wire),
    .acc1_clear_out(acc1_clear_out), .update_apply_out(update_apply_out), .ctrl_word_out(ctrl_word_out));

  // 250 MHz clock
  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  // clear pulses counted so a double pulse cannot hide between checks
  always @(posedge ref_clk_in) begin
    if (acc1_clear_out === 1'b1) n_clr++;
  end

  task automatic summarize;
    $display("counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one byte through the host; ready is sampled at the taking edge
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    #1 cmd_valid_in = 1'b1;
    cmd_addr_in = a;
    cmd_data_in = d;
    do @(posedge ref_clk_in); while (cmd_ready_out !== 1'b1);
    #1 cmd_valid_in = 1'b0;
    repeat (2) @(posedge ref_clk_in);
  endtask : wr

  // one-cycle external strobe request, then let the apply land
  task automatic upd;
    @(posedge ref_clk_in);
    #1 update_req_in = 1'b1;
    @(posedge ref_clk_in);
    #1 update_req_in = 1'b0;
    repeat (3) @(posedge ref_clk_in);
    #1;
  endtask : upd

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    n_mismatch++;
    $display("BAD %0t: run hung", $time);
    summarize();
  end

  initial begin
    logic [7:0] wv[3] = '{8'h03, 8'h0a, 8'h1f};
    logic [4:0] ev[3] = '{5'd4, 5'd10, 5'd20};
    rst_n_in = 1'b0;
    cmd_valid_in = 1'b0;
    cmd_addr_in = 6'h00;
    cmd_data_in = 8'h00;
    update_req_in = 1'b0;
    osk_ramp_in = 12'h5a5;
    repeat (16) @(posedge ref_clk_in);
    #1 rst_n_in = 1'b1;
    chk(ctrl_word_out, CW_RESET);
    chk(isinc_bypass_out, 1'b0);
    chk(lsb_first_out, 1'b0);
    chk(sdo_en_out, 1'b0);
    chk(pll_mult_used_out, 1'b0);
    chk(pll_bypass_out, 1'b1);
    $display("test reset done");
    // multiplier, clamped at both ends of the range
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CW_B2, wv[i]);
      upd();
      chk(pll_mult_out, ev[i]);
    end
    wr(ADDR_CW_B2, 8'h0c);
    repeat (4) @(posedge ref_clk_in);
    #1 chk(pll_mult_out, 5'd20);
    upd();
    chk(pll_mult_out, 5'd12);
    wr(ADDR_CW_B2, 8'h2c);
    upd();
    chk(pll_mult_used_out, 1'b0);
    chk(pll_bypass_out, 1'b1);
    $display("test multiplier done");
    // every mode code, bit 12 set throughout
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_CW_B1, 8'h10 | 8'(m << 1));
      upd();
      chk(mode_out, (m > 4) ? 0 : m);
    end
    $display("test modes done");
    // one-shot clear in chirp and in single tone, then no repeat
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CW_B1, k ? 8'h86 : 8'h80);
      c0 = n_clr;
      upd();
      chk(n_clr - c0, 1);
      upd();
      chk(n_clr - c0, 1);
    end
    wr(ADDR_CW_B1, 8'h40);
    upd();
    chk(acc_hold_out, 1'b1);
    wr(ADDR_CW_B1, 8'h20);
    upd();
    chk(triangle_out, 1'b1);
    chk(mode_out, DCW_MODE_RFSK);
    $display("test clear and sweep done");
    // low byte, reserved bits forced clear by the host
    wr(ADDR_CW_B0, 8'hff);
    upd();
    chk(ctrl_word_out[7:0], 8'h73);
    chk(isinc_clk_en_out, 1'b0);
    chk(isinc_bypass_out, 1'b1);
    chk(osk_en_out, 1'b1);
    chk(osk_scale_cos_out, 12'h5a5);
    chk(osk_internal_out, 1'b1);
    chk(lsb_first_out, 1'b1);
    chk(sdo_en_out, 1'b1);
    wr(ADDR_CW_B0, 8'h20);
    upd();
    chk(osk_internal_out, 1'b0);
    chk(osk_scale_cos_out, 12'h000);
    chk(osk_scale_ctl_out, 12'h000);
    wr(ADDR_OSK_COS_HI, 8'h0a);
    wr(ADDR_OSK_COS_LO, 8'hbc);
    wr(ADDR_OSK_CTL_HI, 8'h03);
    wr(ADDR_OSK_CTL_LO, 8'h21);
    upd();
    chk(osk_scale_cos_out, 12'habc);
    chk(osk_scale_ctl_out, 12'h321);
    $display("test keying done");
    // internal strobe: writes apply with no request from the host
    wr(ADDR_CW_B1, 8'h01);
    upd();
    chk(int_update_out, 1'b1);
    wr(ADDR_CW_B2, 8'h0b);
    repeat (3) @(posedge ref_clk_in);
    #1 chk(pll_mult_out, 5'd11);
    chk(pll_bypass_out, 1'b0);
    chk(pll_mult_used_out, 1'b1);
    $display("test internal strobe done");
    // mid-run reset drops internal strobe mode on both ends
    @(posedge ref_clk_in);
    #1 rst_n_in = 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #1 rst_n_in = 1'b1;
    chk(ctrl_word_out, CW_RESET);
    chk(int_update_out, 1'b0);
    wr(ADDR_CW_B2, 8'h14);
    upd();
    chk(pll_mult_out, 5'd20);
    $display("test mid-run reset done");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
